// File: core/acmp_defs.vh
/*
 defines for the comparator control block: register offsets, field
 positions, reset values, event mode codes and interrupt bits.
 assumes inclusion by bare name from the design files under core/.
*/
`ifndef ACMP_DEFS_VH
`define ACMP_DEFS_VH

// apb byte addresses
`define ACMP_ADDR_CTRL    12'h000
`define ACMP_ADDR_SFIO    12'h004
`define ACMP_ADDR_ISTAT   12'h008
`define ACMP_ADDR_IMASK   12'h00C

// control/status field positions
`define ACMP_BIT_DISABLE  7
`define ACMP_BIT_BANDGAP  6
`define ACMP_BIT_OUTSTAT  5
`define ACMP_BIT_FLAG     4
`define ACMP_BIT_IRQEN    3
`define ACMP_BIT_CAPRT    2
`define ACMP_BIT_MODEHI   1
`define ACMP_BIT_MODELO   0

// special function field position
`define ACMP_BIT_MUXNEG   3

// event mode codes
`define ACMP_MODE_TOGGLE  2'h0
`define ACMP_MODE_RSVD    2'h1
`define ACMP_MODE_FALL    2'h2
`define ACMP_MODE_RISE    2'h3

// sticky interrupt status bits
`define ACMP_IST_EDGE     0
`define ACMP_IST_RISE     1
`define ACMP_IST_FALL     2

// reset values
`define ACMP_RST_CTRL     8'h00
`define ACMP_RST_SFIO     8'h00
`define ACMP_RST_IMASK    3'h0

`endif

// File: core/acmp_sync.v
/*
 two flip-flop synchronizer for one asynchronous level.
 assumes input comes from the analog comparator or a pin.
*/
`timescale 1ns/1ps
module acmp_sync
(
   input  wire clock,
   input  wire sys_rst,
   input  wire asyncIn,
   output wire syncOut
);
   reg stage1_ff;
   reg stage2_ff;

   // first stage feeds only the second stage
   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         stage1_ff <= 1'b0;
         stage2_ff <= 1'b0;
      end
      else
      begin
         stage1_ff <= asyncIn;
         stage2_ff <= stage1_ff;
      end
   end

   assign syncOut = stage2_ff;
endmodule // acmp_sync

// File: core/acmp_ctrl.v
/*
 comparator control logic: control/status and special function
 registers over apb, output synchronizer, edge-event flag, cpu irq,
 capture routing, positive/negative input selection, and a sticky
 status/mask interrupt pair.
 assumes a single 10 MHz clock, the analog core producing compRaw
 from the selections driven here, and the cpu giving vector ack.
*/
`timescale 1ns/1ps
`include "acmp_defs.vh"
module acmp_ctrl
(
   input  wire        clock,
   input  wire        sys_rst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        compRaw,
   input  wire        converterEnable,
   input  wire [2:0]  channelSelect,
   input  wire        globalIrqEnable,
   input  wire        vectorAck,
   output reg         compPowerDown,
   output reg         bandgapSelect,
   output reg         negUseMux,
   output reg  [7:0]  negChannelOneHot,
   output reg         compIrqReq,
   output reg         captureTrigger,
   output reg         irqOut
);
   // control/status storage (output status bit not stored here)
   reg        disable_ff;
   reg        bandgap_ff;
   reg        flag_ff;
   reg        irqEn_ff;
   reg        capRoute_ff;
   reg [1:0]  mode_ff;
   reg        muxNeg_ff;
   reg [2:0]  istat_ff;
   reg [2:0]  imask_ff;
   reg        prevOut_ff;
   reg        nxt_flag;
   reg [2:0]  nxt_istat;
   reg [31:0] nxt_prdata;
   reg        nxt_slverr;
   reg        nxtNegMux;

   wire       syncOut;
   wire       apbAccess;
   wire       wrCtrl;
   wire       wrSfio;
   wire       wrIstat;
   wire       wrImask;
   wire       riseEdge;
   wire       fallEdge;
   wire       modeHit;

   // comparator core output through two flops, 1-2 cycle delay
   acmp_sync u_sync
   (
      .clock   (clock),
      .sys_rst (sys_rst),
      .asyncIn (compRaw),
      .syncOut (syncOut)
   );

   // one wait state: pready is registered, so the access phase completes on the second edge
   assign apbAccess = psel & penable & ~pready;
   assign wrCtrl  = apbAccess & pwrite & (paddr == `ACMP_ADDR_CTRL);
   assign wrSfio  = apbAccess & pwrite & (paddr == `ACMP_ADDR_SFIO);
   assign wrIstat = apbAccess & pwrite & (paddr == `ACMP_ADDR_ISTAT);
   assign wrImask = apbAccess & pwrite & (paddr == `ACMP_ADDR_IMASK);

   // edges against last cycle's synchronized value
   assign riseEdge = syncOut & ~prevOut_ff;
   assign fallEdge = ~syncOut & prevOut_ff;

   // event mode decode; reserved code never fires
   function mode_match;
      input [1:0] mode;
      input       rise;
      input       fall;
      begin
         case (mode)
            `ACMP_MODE_TOGGLE: mode_match = rise | fall;
            `ACMP_MODE_FALL:   mode_match = fall;
            `ACMP_MODE_RISE:   mode_match = rise;
            default:           mode_match = 1'b0;
         endcase
      end
   endfunction

   // a powered-down comparator raises no events
   assign modeHit = ~disable_ff & mode_match(mode_ff, riseEdge, fallEdge);

   // flag: set beats the vector or write-one clear
   always @*
   begin
      nxt_flag = flag_ff;
      if (vectorAck)
         nxt_flag = 1'b0;
      if (wrCtrl && pwdata[`ACMP_BIT_FLAG])
         nxt_flag = 1'b0;
      if (modeHit)
         nxt_flag = 1'b1;
   end

   // sticky status: write one clears, new event wins
   always @*
   begin
      nxt_istat = istat_ff;
      if (wrIstat)
         nxt_istat = istat_ff & ~pwdata[2:0];
      if (modeHit)
         nxt_istat[`ACMP_IST_EDGE] = 1'b1;
      if (riseEdge && !disable_ff)
         nxt_istat[`ACMP_IST_RISE] = 1'b1;
      if (fallEdge && !disable_ff)
         nxt_istat[`ACMP_IST_FALL] = 1'b1;
   end

   // read mux; unmapped addresses answer with slverr and zero
   always @*
   begin
      nxt_prdata = 32'h00000000;
      nxt_slverr = 1'b0;
      case (paddr)
         `ACMP_ADDR_CTRL:
            nxt_prdata[7:0] = {disable_ff, bandgap_ff, syncOut,
                               flag_ff, irqEn_ff, capRoute_ff,
                               mode_ff};
         `ACMP_ADDR_SFIO:
            nxt_prdata[`ACMP_BIT_MUXNEG] = muxNeg_ff;
         `ACMP_ADDR_ISTAT:
            nxt_prdata[2:0] = istat_ff;
         `ACMP_ADDR_IMASK:
            nxt_prdata[2:0] = imask_ff;
         default:
            nxt_slverr = 1'b1;
      endcase
   end

   // mux path only when enabled and converter is off
   always @*
   begin
      nxtNegMux = muxNeg_ff & ~converterEnable;
   end

   // register file and bus answer
   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         disable_ff  <= 1'b0;
         bandgap_ff  <= 1'b0;
         irqEn_ff    <= 1'b0;
         capRoute_ff <= 1'b0;
         mode_ff     <= 2'h0;
         muxNeg_ff   <= 1'b0;
         imask_ff    <= `ACMP_RST_IMASK;
         pready      <= 1'b0;
         pslverr     <= 1'b0;
         prdata      <= 32'h00000000;
      end
      else
      begin
         pready <= apbAccess;
         if (apbAccess)
         begin
            pslverr <= nxt_slverr;
            prdata  <= pwrite ? 32'h00000000 : nxt_prdata;
         end
         else
         begin
            pslverr <= 1'b0;
         end
         // the disable bit may change at any time
         if (wrCtrl)
         begin
            disable_ff  <= pwdata[`ACMP_BIT_DISABLE];
            bandgap_ff  <= pwdata[`ACMP_BIT_BANDGAP];
            irqEn_ff    <= pwdata[`ACMP_BIT_IRQEN];
            capRoute_ff <= pwdata[`ACMP_BIT_CAPRT];
            mode_ff     <= pwdata[`ACMP_BIT_MODEHI:`ACMP_BIT_MODELO];
         end
         if (wrSfio)
            muxNeg_ff <= pwdata[`ACMP_BIT_MUXNEG];
         if (wrImask)
            imask_ff <= pwdata[2:0];
      end
   end

   // event state and registered outputs
   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         flag_ff          <= 1'b0;
         istat_ff         <= 3'h0;
         prevOut_ff       <= 1'b0;
         compPowerDown    <= 1'b0;
         bandgapSelect    <= 1'b0;
         negUseMux        <= 1'b0;
         negChannelOneHot <= 8'h00;
         compIrqReq       <= 1'b0;
         captureTrigger   <= 1'b0;
         irqOut           <= 1'b0;
      end
      else
      begin
         flag_ff       <= nxt_flag;
         istat_ff      <= nxt_istat;
         prevOut_ff    <= syncOut;
         compPowerDown <= disable_ff;
         bandgapSelect <= bandgap_ff;
         negUseMux     <= nxtNegMux;
         // one hot channel enable; all zero selects the negative pin
         negChannelOneHot <= nxtNegMux ?
                             (8'h01 << channelSelect) : 8'h00;
         compIrqReq <= flag_ff & irqEn_ff & globalIrqEnable;
         // route gated here; capture filter lives in the timer
         captureTrigger <= capRoute_ff & syncOut;
         irqOut <= |(istat_ff & imask_ff);
      end
   end
endmodule // acmp_ctrl

// File: verification/acmp_ctrl_checker.sv
/*
 port checker for acmp_ctrl: bus answer, refusal, irq gating,
 negative input routing and capture path.
 assumes it is bound onto acmp_ctrl and sees only its ports.
*/
`timescale 1ns/1ps
module acmp_ctrl_checker
(
   input wire        clock,
   input wire        sys_rst,
   input wire        psel,
   input wire        penable,
   input wire [11:0] paddr,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        compRaw,
   input wire        converterEnable,
   input wire [2:0]  channelSelect,
   input wire        globalIrqEnable,
   input wire        negUseMux,
   input wire [7:0]  negChannelOneHot,
   input wire        compIrqReq,
   input wire        captureTrigger
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   // bus answers with exactly one wait state
   AST_ANSWER: assert property (psel && penable && !pready |=> pready)
      else $error("no answer one cycle after access");
   AST_PULSE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_REFUSE: assert property (pslverr |-> pready &&
      !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C}))
      else $error("error on a mapped address");
   AST_UPPER: assert property (pready |-> prdata[31:8] == 24'h000000)
      else $error("upper read bits not zero");
   // request only with the global enable behind it
   AST_GATE: assert property (compIrqReq |-> $past(globalIrqEnable))
      else $error("request without global enable");
   // converter on forces the dedicated pin
   AST_MUXOFF: assert property (converterEnable |=> !negUseMux)
      else $error("mux used while converter on");
   AST_NOCHAN: assert property (!negUseMux |->
      negChannelOneHot == 8'h00)
      else $error("channel picked without mux");
   AST_CHAN: assert property (negUseMux |->
      negChannelOneHot == (8'h01 << $past(channelSelect)))
      else $error("wrong channel picked");
   // sync latency plus output register, so a window of depths
   AST_CAPT: assert property (captureTrigger |->
      $past(compRaw, 2) || $past(compRaw, 3) || $past(compRaw, 4))
      else $error("capture without comparator high");
endmodule // acmp_ctrl_checker

bind acmp_ctrl acmp_ctrl_checker acmp_ctrl_checker_i (.*);

// File: verification/acmp_core_model.sv
/*
 behavioural analog comparator core with input selection.
 assumes levels as 8-bit codes driven by the bench.
*/
`timescale 1ns/1ps
module acmp_core_model
#(
   parameter [7:0] BG_LVL = 8'h40
)
(
   input  wire       compPowerDown,
   input  wire       bandgapSelect,
   input  wire       negUseMux,
   input  wire [7:0] negChannelOneHot,
   input  wire [7:0] posLvl,
   input  wire [7:0] negLvl,
   output reg        compRaw
);
   integer   n;
   reg [7:0] posSel;
   reg [7:0] negSel;

   // channel n sits at n*32 so every pick gives a distinct level
   always @*
   begin
      posSel = bandgapSelect ? BG_LVL : posLvl;
      negSel = negLvl;
      for (n = 0; n < 8; n = n + 1)
         if (negUseMux && negChannelOneHot[n])
            negSel = {n[2:0], 5'h00};
      compRaw = !compPowerDown && (posSel > negSel);
   end
endmodule // acmp_core_model

// File: verification/acmp_ctrl_tb.sv
/*
 self-checking bench for acmp_ctrl over apb with a comparator model.
 assumes the 10 MHz clock and one wait state per access.
*/
`timescale 1ns/1ps
module acmp_ctrl_tb;
   reg         clock = 1'h0;
   reg         sys_rst = 1'h1;
   reg         psel = 1'h0;
   reg         penable = 1'h0;
   reg         pwrite = 1'h0;
   reg  [11:0] paddr = 12'h000;
   reg  [31:0] pwdata = 32'h0;
   reg         converterEnable = 1'h0;
   reg  [2:0]  channelSelect = 3'h0;
   reg         globalIrqEnable = 1'h0;
   reg         vectorAck = 1'h0;
   reg  [7:0]  posLvl = 8'h20;
   reg  [7:0]  negLvl = 8'h80;
   wire [31:0] prdata;
   wire        pready, pslverr, compRaw, compPowerDown, bandgapSelect;
   wire        negUseMux, compIrqReq, captureTrigger, irqOut;
   wire [7:0]  negChannelOneHot;
   integer     failures = 0;
   integer     total_checks = 0;
   integer     i;
   reg  [31:0] rd;
   reg         err;
   reg  [1:0]  mode;
   // expected flag per mode step: toggle, reserved, fall, rise, rise
   reg  [4:0]  flagPat = 5'h0D;

   acmp_ctrl acmp_ctrl_i (.*);
   acmp_core_model acmp_core_model_i (.*);

   initial forever #50 clock = ~clock;

   task check(input [32:0] seen, input [32:0] exp);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp)
         begin
            failures = failures + 1;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask

   // one apb transfer; held until pready is seen at an edge
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge clock);
         psel <= 1'h1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge clock);
         penable <= 1'h1;
         // only the watchdog ends a wait that never sees pready
         do
            @(posedge clock);
         while (pready !== 1'h1);
         rd = prdata;
         err = pslverr;
         psel <= 1'h0;
         penable <= 1'h0;
      end
   endtask

   task wt(input integer k);
      repeat (k) @(posedge clock);
   endtask

   task report_and_stop;
      begin
         $display("checks=%0d mismatches=%0d", total_checks, failures);
         if (failures == 0 && total_checks > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask

   // sequences stay far below this, so reaching it means a hang
   initial
   begin
      #300000;
      failures = failures + 1;
      report_and_stop;
   end

   initial
   begin
      wt(8);
      sys_rst <= 1'h0;
      for (i = 0; i < 5; i = i + 1)
      begin
         apb(1'h0, i * 4, 32'h0);
         check({err, rd}, {i == 4, 32'h0});
      end
      $display("test reset and refusal done");
      posLvl <= 8'hC0;
      wt(6);
      apb(1'h0, 12'h000, 32'h0);
      check(rd, 32'h30);
      apb(1'h1, 12'h000, 32'h10);
      apb(1'h0, 12'h000, 32'h0);
      check(rd, 32'h20);
      // irq enable stays clear while the mode changes
      for (i = 0; i < 5; i = i + 1)
      begin
         mode = (i > 3) ? 2'h3 : i[1:0];
         apb(1'h1, 12'h000, {28'h1, 2'h0, mode});
         posLvl <= i[0] ? 8'hC0 : 8'h20;
         wt(6);
         apb(1'h0, 12'h000, 32'h0);
         check(rd, {26'h0, i[0], flagPat[i], 2'h0, mode});
      end
      $display("test event modes done");
      apb(1'h1, 12'h000, 32'h0B);
      globalIrqEnable <= 1'h1;
      posLvl <= 8'hC0;
      wt(6);
      check(compIrqReq, 1'h1);
      check(irqOut, 1'h0);
      apb(1'h1, 12'h00C, 32'h7);
      wt(3);
      check(irqOut, 1'h1);
      apb(1'h1, 12'h008, 32'h7);
      wt(3);
      check(irqOut, 1'h0);
      vectorAck <= 1'h1;
      @(posedge clock);
      vectorAck <= 1'h0;
      wt(3);
      check(compIrqReq, 1'h0);
      globalIrqEnable <= 1'h0;
      posLvl <= 8'h20;
      wt(6);
      posLvl <= 8'hC0;
      wt(6);
      check(compIrqReq, 1'h0);
      apb(1'h0, 12'h000, 32'h0);
      check(rd, 32'h3B);
      $display("test interrupts done");
      apb(1'h1, 12'h000, 32'h44);
      wt(6);
      check({compPowerDown, bandgapSelect, captureTrigger}, 3'h2);
      apb(1'h1, 12'h000, 32'h04);
      wt(6);
      check({compPowerDown, bandgapSelect, captureTrigger}, 3'h1);
      apb(1'h1, 12'h000, 32'h84);
      wt(6);
      check({compPowerDown, bandgapSelect, captureTrigger}, 3'h4);
      apb(1'h1, 12'h004, 32'h08);
      for (i = 0; i < 8; i = i + 1)
      begin
         channelSelect <= i[2:0];
         wt(2);
         check({negUseMux, negChannelOneHot}, {1'h1, 8'h01 << i});
      end
      converterEnable <= 1'h1;
      wt(2);
      check({negUseMux, negChannelOneHot}, 9'h000);
      $display("test input routing done");
      report_and_stop;
   end
endmodule // acmp_ctrl_tb
